// >>> common/sbs_pkg.sv
// Constants and types shared by the synchronous burst SRAM port
package sbs_pkg;

   // Data organisation
   localparam int LANES = 4;                 // Byte lanes on the data bus
   localparam int LANE_W = 9;                // Bits per lane, parity included
   localparam int WORD_W = LANES * LANE_W;   // Full word, 36 bits

   // Address organisation
   localparam int ADDR_W = 18;               // Word address width
   localparam int CNT_W = 2;                 // Internal burst counter width
   localparam int HI_W = ADDR_W - CNT_W;     // Address bits never counted
   localparam int MEM_DEPTH = 1 << ADDR_W;   // Words in the array

   // Reset values and fixed patterns
   localparam logic [CNT_W-1:0] CNT_RST = 2'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 2'h1;
   localparam logic [HI_W-1:0] HI_RST = 16'h0000;
   localparam logic [WORD_W-1:0] WORD_RST = 36'h0_0000_0000;
   localparam logic [LANES-1:0] LANES_ALL = 4'hf;
   localparam logic [LANES-1:0] LANES_NONE = 4'h0;

   // Kind of the cycle registered at the last edge
   typedef enum logic [1:0]
   {
      SBS_DESEL = 2'h0,   // Not selected, outputs idle
      SBS_READ = 2'h1,    // Selected read cycle
      SBS_WRITE = 2'h3,   // Selected write cycle
      SBS_SLEEP = 2'h2    // Low-power standby
   } sbs_cycle_t;

   // Whole registered state of the port
   typedef struct packed
   {
      sbs_cycle_t kind;              // Cycle registered at the last edge
      logic [HI_W-1:0] addr_hi;      // Loaded upper address
      logic [CNT_W-1:0] start_lo;    // Loaded low address bits
      logic [CNT_W-1:0] step;        // Burst steps taken since load
      logic rd_vld;                  // Pipelined read data is valid
      logic [WORD_W-1:0] rd_data;    // Pipelined read data
   } sbs_state_t;

   // State after reset
   localparam sbs_state_t STATE_RST = '{
      kind: SBS_DESEL,
      addr_hi: HI_RST,
      start_lo: CNT_RST,
      step: CNT_RST,
      rd_vld: 1'b0,
      rd_data: WORD_RST
   };

endpackage : sbs_pkg

// >>> testbench/sbs_chk.sv
// Pin-level assertions for the burst SRAM port
`timescale 1ns/1ps
module sbs_chk (
   // Clock, reset and asynchronous controls
   input wire logic clk_sys_in, rst_n_in, clk_en_in, sleep_request_in,
   input wire logic output_enable_n_in,
   // Selects and strobes
   input wire logic chip_select_n_in, secondary_chip_select_in,
   input wire logic secondary_chip_select_n_in,
   input wire logic proc_address_strobe_n_in, ctrl_address_strobe_n_in,
   // Write controls
   input wire logic global_write_n_in, byte_write_gate_n_in,
   input wire logic lane0_write_n_in, lane1_write_n_in,
   input wire logic lane2_write_n_in, lane3_write_n_in,
   // Watched outputs
   input wire logic data_lane0_oe_out, standby_out
);
   logic [1:0] up_q; // Edges seen since reset release
   logic up, sel, gat, go, wr, rd, wl, ds;
   // Requests count only once internal reset is over
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
      if (!rst_n_in)
         up_q <= 2'h0;
      else
         up_q <= {up_q[0], 1'b1};
   assign up = up_q[1];
   assign sel = !chip_select_n_in && secondary_chip_select_in &&
      !secondary_chip_select_n_in;
   assign gat = !byte_write_gate_n_in && !(lane0_write_n_in &&
      lane1_write_n_in && lane2_write_n_in && lane3_write_n_in);
   assign go = up && clk_en_in && !sleep_request_in;
   assign wr = !global_write_n_in || gat;
   assign rd = go && sel && (!proc_address_strobe_n_in ||
      (!ctrl_address_strobe_n_in && !wr));
   assign wl = go && sel && proc_address_strobe_n_in &&
      !ctrl_address_strobe_n_in && wr;
   assign ds = go && !sel && (!ctrl_address_strobe_n_in ||
      (!proc_address_strobe_n_in && !chip_select_n_in));
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   a_oe_async_off: assert property (output_enable_n_in |->
      !data_lane0_oe_out) else $error("drivers on with enable high");
   a_gated_write_off: assert property (gat |->
      !data_lane0_oe_out) else $error("drivers on during byte write");
   a_sleep_quiet: assert property (sleep_request_in |->
      !data_lane0_oe_out) else $error("drivers on in standby");
   a_sleep_entry: assert property (up && clk_en_in &&
      sleep_request_in |=> standby_out) else $error("standby not entered");
   a_sleep_exit: assert property (standby_out && clk_en_in &&
      !sleep_request_in |=> !standby_out) else $error("standby kept");
   a_read_drives: assert property (rd ##1 go |=>
      output_enable_n_in || sleep_request_in || gat || data_lane0_oe_out)
      else $error("read data not driven");
   a_write_quiet: assert property (wl ##1 clk_en_in |=>
      !data_lane0_oe_out) else $error("drivers on after write");
   a_desel_quiet: assert property (ds ##1 clk_en_in |=>
      !data_lane0_oe_out) else $error("drivers on after deselect");
   c_read: cover property (rd ##2 data_lane0_oe_out);
   c_gated: cover property (gat && !output_enable_n_in);
   c_sleep: cover property (standby_out);
endmodule : sbs_chk

bind sbs_sram_port sbs_chk u_chk (
   .clk_sys_in(clk_sys_in),
   .rst_n_in(rst_n_in),
   .clk_en_in(clk_en_in),
   .sleep_request_in(sleep_request_in),
   .output_enable_n_in(output_enable_n_in),
   .chip_select_n_in(chip_select_n_in),
   .secondary_chip_select_in(secondary_chip_select_in),
   .secondary_chip_select_n_in(secondary_chip_select_n_in),
   .proc_address_strobe_n_in(proc_address_strobe_n_in),
   .ctrl_address_strobe_n_in(ctrl_address_strobe_n_in),
   .global_write_n_in(global_write_n_in),
   .byte_write_gate_n_in(byte_write_gate_n_in),
   .lane0_write_n_in(lane0_write_n_in),
   .lane1_write_n_in(lane1_write_n_in),
   .lane2_write_n_in(lane2_write_n_in),
   .lane3_write_n_in(lane3_write_n_in),
   .data_lane0_oe_out(data_lane0_oe_out),
   .standby_out(standby_out)
);

// >>> testbench/sbs_master.sv
// Memory controller model that drives the burst SRAM port
`timescale 1ns/1ps
module sbs_master (
   // Clock and device side of the data wires
   input wire logic clk_sys_in,
   input wire logic [35:0] q_in,
   input wire logic oe_in,
   // Controls: cs_n, cs2, proc_n, ctrl_n, step_n, gw_n
   output logic [5:0] ctl_out,
   output logic [4:0] wr_out,
   output logic [1:0] lo_out,
   output wire logic [35:0] d_out
);
   logic [35:0] drv = 36'h0_0000_0000; // Word the model drives
   // Wires carry the device word while it drives them
   assign d_out = oe_in ? q_in : drv;
   initial
   begin
      ctl_out = 6'h2f;
      wr_out = 5'h1f;
      lo_out = 2'h0;
   end
   // One bus cycle: change after falling edge, hold over rising edge
   task automatic cyc(input logic [5:0] c, input logic [4:0] w,
      input logic [1:0] lo, input logic [35:0] d);
      ctl_out = c;
      wr_out = w;
      lo_out = lo;
      // Released wires show the inverse, never the stale word
      drv = (c[0] && (w[4] || &w[3:0])) ? ~drv : d;
      @(posedge clk_sys_in);
      @(negedge clk_sys_in);
   endtask : cyc
endmodule : sbs_master

// >>> testbench/sbs_sram_port_tb.sv
// Self-checking testbench for the burst SRAM port
`timescale 1ns/1ps
module sbs_sram_port_tb;
   import sbs_pkg::*;
   // Control codes: cs_n, cs2, proc_n, ctrl_n, step_n, gw_n
   localparam logic [5:0] LDW = 6'h1a, LDR = 6'h1b, CW = 6'h1c;
   localparam logic [5:0] CR = 6'h1d, WT = 6'h1f, DS = 6'h0b;
   // PX: stepping cycle with processor strobe but primary select high
   localparam logic [5:0] PX = 6'h35, PL = 6'h16;
   // Write codes: gate, lanes 3..0
   localparam logic [4:0] NW = 5'h1f, BW = 5'h0d, GH = 5'h10;
   localparam logic [4:0] BL = 5'h06; // Lanes 3 and 0 gated
   localparam logic [35:0] ALL = 36'h0_0000_000f;
   logic clk_sys_in = 1'b0, rst_n_in = 1'b0, order = 1'b0;
   logic oe_n = 1'b0, slp = 1'b0, cs2_n = 1'b0;
   wire [5:0] c;
   wire [4:0] w;
   wire [1:0] lo;
   wire [35:0] q, d;
   wire [3:0] oe;
   wire stby;
   logic [35:0] exp_q [4]; // Expected words at low addresses
   int failures = 0, samples_checked = 0;
   sbs_sram_port u_sbs_sram_port (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
      .addr_hi_in(16'h00a5), .burst_addr_bit_zero_in(lo[0]),
      .burst_addr_bit_one_in(lo[1]), .chip_select_n_in(c[5]),
      .secondary_chip_select_in(c[4]), .secondary_chip_select_n_in(cs2_n),
      .proc_address_strobe_n_in(c[3]), .ctrl_address_strobe_n_in(c[2]),
      .burst_step_n_in(c[1]), .burst_order_in(order),
      .global_write_n_in(c[0]), .byte_write_gate_n_in(w[4]),
      .lane0_write_n_in(w[0]), .lane1_write_n_in(w[1]),
      .lane2_write_n_in(w[2]), .lane3_write_n_in(w[3]),
      .output_enable_n_in(oe_n), .sleep_request_in(slp),
      .data_lane0_in(d[8:0]), .data_lane1_in(d[17:9]),
      .data_lane2_in(d[26:18]), .data_lane3_in(d[35:27]),
      .data_lane0_out(q[8:0]), .data_lane1_out(q[17:9]),
      .data_lane2_out(q[26:18]), .data_lane3_out(q[35:27]),
      .data_lane0_oe_out(oe[0]), .data_lane1_oe_out(oe[1]),
      .data_lane2_oe_out(oe[2]), .data_lane3_oe_out(oe[3]),
      .standby_out(stby));
   sbs_master u_m (.clk_sys_in(clk_sys_in), .q_in(q), .oe_in(oe[0]),
      .ctl_out(c), .wr_out(w), .lo_out(lo), .d_out(d));
   initial
      forever #12.5 clk_sys_in = ~clk_sys_in;
   // Compare and count
   task automatic chk(input string n, input logic [35:0] e, g);
      samples_checked++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Four-cycle read burst, optional wait after the first word
   task automatic rd_burst(input logic [1:0] a, input logic wt);
      logic [1:0] k2;
      u_m.cyc(LDR, NW, a, WORD_RST);
      for (int k = 0; k < 4; k++)
      begin
         u_m.cyc((k == 0 && wt) ? WT : (k < 3 ? CR : DS), NW, a, WORD_RST);
         k2 = 2'(k - ((wt && k > 0) ? 1 : 0));
         chk("read word", exp_q[order ? a ^ k2 : a + k2], q);
         chk("read enable", ALL, 36'(oe));
      end
   endtask : rd_burst
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up
   // Watchdog
   initial
   begin
      #20us;
      failures++;
      wrap_up();
   end
   initial
   begin
      repeat (20) @(negedge clk_sys_in);
      rst_n_in = 1'b1;
      repeat (3) @(negedge clk_sys_in);
      chk("reset outputs", WORD_RST, 36'({oe, stby}));
      // Linear global-write burst from low address 2
      for (int k = 0; k < 4; k++)
      begin
         exp_q[2'(k + 2)] = 36'h1_0204_0801 * 36'(k + 3);
         u_m.cyc(k ? CW : LDW, NW, 2'h2, exp_q[2'(k + 2)]);
      end
      u_m.cyc(DS, NW, 2'h0, WORD_RST);
      rd_burst(2'h2, 1'b0);
      order = 1'b1;
      rd_burst(2'h1, 1'b0);
      rd_burst(2'h3, 1'b1);
      order = 1'b0;
      // Lane 1 only, then lane enables without the gate
      u_m.cyc(LDR, BW, 2'h3, 36'h5_5555_5555);
      exp_q[3][17:9] = 9'h0aa;
      // Lanes 3 and 0 together at low address 0
      u_m.cyc(LDR, BL, 2'h0, 36'h5_5555_5555);
      exp_q[0][8:0] = 9'h155;
      exp_q[0][35:27] = 9'h0aa;
      u_m.cyc(LDR, GH, 2'h0, 36'h5_5555_5555);
      u_m.cyc(DS, NW, 2'h0, WORD_RST);
      chk("ungated read", exp_q[0], q);
      rd_burst(2'h3, 1'b0);
      // Ungated processor strobe mid-burst must not break the burst
      u_m.cyc(LDR, NW, 2'h2, WORD_RST);
      u_m.cyc(PX, NW, 2'h0, WORD_RST);
      u_m.cyc(DS, NW, 2'h0, WORD_RST);
      chk("ignored strobe", exp_q[3], q);
      chk("ignored strobe enable", ALL, 36'(oe));
      u_m.cyc(DS, NW, 2'h0, WORD_RST);
      chk("after deselect", WORD_RST, 36'(oe));
      // Active-low secondary select high deselects a load
      cs2_n = 1'b1;
      u_m.cyc(LDR, NW, 2'h2, WORD_RST);
      cs2_n = 1'b0;
      u_m.cyc(DS, NW, 2'h0, WORD_RST);
      chk("low select off", WORD_RST, 36'(oe));
      // Processor strobe with the primary select, write ignored
      u_m.cyc(PL, NW, 2'h2, WORD_RST);
      u_m.cyc(DS, NW, 2'h0, WORD_RST);
      chk("proc read", exp_q[2], q);
      oe_n = 1'b1;
      #1 chk("enable off", WORD_RST, 36'(oe));
      oe_n = 1'b0;
      #1 chk("enable on", ALL, 36'(oe));
      // Gated lane enable turns the drivers off at once
      u_m.wr_out = BW;
      #1 chk("gated write off", WORD_RST, 36'(oe));
      u_m.wr_out = NW;
      #1 slp = 1'b1;
      u_m.cyc(DS, NW, 2'h0, WORD_RST);
      chk("standby", 36'h0_0000_0001, 36'(stby));
      slp = 1'b0;
      u_m.cyc(DS, NW, 2'h0, WORD_RST);
      chk("awake", WORD_RST, 36'(stby));
      wrap_up();
   end
endmodule : sbs_sram_port_tb

// >>> verilog/sbs_sram_port.sv
// Synchronous pipelined burst SRAM port with byte lanes and burst counter
//
// Functional notes
// - All synchronous inputs captured on rising edge
// - Burst cycles take low bits from counter
// - Low lane enable writes; all high reads
// - Each lane enable controls its own lane
// - Data outputs off during gated byte write
// - Byte-write gate low qualifies lane enables
// - Global write low writes whole word
// - Primary select enables and gates processor strobe
// - Selected only when all three selects true
// - Output enable switches drivers without clock
// - Step input advances counter; high holds it
// - Processor strobe loads address, starts read
// - Controller strobe loads address, read or write
// - Order input: low linear, high interleaved
// - Sleep input high enters low-power standby
// - Two-bit counter wraps after four words
// - Lane enables need gate; global forces all
`timescale 1ns/1ps

module sbs_sram_port
(
   // Clock, reset and clock enable
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   // Address
   input wire logic [sbs_pkg::HI_W-1:0] addr_hi_in,
   input wire logic burst_addr_bit_zero_in,
   input wire logic burst_addr_bit_one_in,
   // Chip selects
   input wire logic chip_select_n_in,
   input wire logic secondary_chip_select_in,
   input wire logic secondary_chip_select_n_in,
   // Address strobes and burst control
   input wire logic proc_address_strobe_n_in,
   input wire logic ctrl_address_strobe_n_in,
   input wire logic burst_step_n_in,
   input wire logic burst_order_in,
   // Write controls
   input wire logic global_write_n_in,
   input wire logic byte_write_gate_n_in,
   input wire logic lane0_write_n_in,
   input wire logic lane1_write_n_in,
   input wire logic lane2_write_n_in,
   input wire logic lane3_write_n_in,
   // Asynchronous controls
   input wire logic output_enable_n_in,
   input wire logic sleep_request_in,
   // Data lane inputs
   input wire logic [sbs_pkg::LANE_W-1:0] data_lane0_in,
   input wire logic [sbs_pkg::LANE_W-1:0] data_lane1_in,
   input wire logic [sbs_pkg::LANE_W-1:0] data_lane2_in,
   input wire logic [sbs_pkg::LANE_W-1:0] data_lane3_in,
   // Data lane outputs
   output logic [sbs_pkg::LANE_W-1:0] data_lane0_out,
   output logic [sbs_pkg::LANE_W-1:0] data_lane1_out,
   output logic [sbs_pkg::LANE_W-1:0] data_lane2_out,
   output logic [sbs_pkg::LANE_W-1:0] data_lane3_out,
   // Data lane output enables
   output logic data_lane0_oe_out,
   output logic data_lane1_oe_out,
   output logic data_lane2_oe_out,
   output logic data_lane3_oe_out,
   // Status
   output logic standby_out
);
   import sbs_pkg::*;

   // Reset synchroniser stages
   logic [1:0] rst_sync_q;
   // Released reset used by the rest of the port
   logic rst_n;
   // Registered state and its next value
   sbs_state_t st_q;
   sbs_state_t st_d;
   // Decoded selects and strobes
   logic sel_now;
   logic proc_load;
   logic ctrl_load;
   logic active;
   // Lane write enables as a vector, active low
   logic [LANES-1:0] lane_n;
   // Lanes to be written this edge
   logic [LANES-1:0] lane_mask;
   logic [LANES-1:0] wr_lane;
   // Write and read addresses
   logic [ADDR_W-1:0] wr_addr;
   logic [ADDR_W-1:0] rd_addr;
   // Incoming and stored word
   logic [WORD_W-1:0] din_word;
   logic [WORD_W-1:0] mem_word;
   // Shared output driver enable
   logic drive;

   // Low address bits from start value and step count
   function automatic logic [CNT_W-1:0] burst_lo
   (
      input logic [CNT_W-1:0] start,
      input logic [CNT_W-1:0] step,
      input logic interleaved
   );
      logic [CNT_W-1:0] lo;
      if (interleaved)
      begin
         lo = start ^ step;
      end
      else
      begin
         lo = CNT_W'(start + step);
      end
      return lo;
   endfunction : burst_lo

   // Reset release through two flip-flops
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rst_sync_q <= 2'h0;
      end
      else
      begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_q[1];

   // Lane enables gathered, lane k controls data lane k
   assign lane_n = {lane3_write_n_in, lane2_write_n_in,
                    lane1_write_n_in, lane0_write_n_in};
   assign din_word = {data_lane3_in, data_lane2_in,
                      data_lane1_in, data_lane0_in};

   // Device selected only with all three selects true
   assign sel_now = !chip_select_n_in && secondary_chip_select_in &&
                    !secondary_chip_select_n_in;

   // Processor strobe counts only with primary select low
   assign proc_load = !sleep_request_in && !proc_address_strobe_n_in &&
                      !chip_select_n_in;
   // Controller strobe, processor strobe takes priority
   assign ctrl_load = !sleep_request_in && !ctrl_address_strobe_n_in &&
                      !proc_load;

   // A burst is running after a selected load
   assign active = (st_q.kind == SBS_READ) || (st_q.kind == SBS_WRITE);

   // Lanes written: global write, else gated lane enables
   always_comb
   begin
      if (!global_write_n_in)
      begin
         lane_mask = LANES_ALL;
      end
      else if (!byte_write_gate_n_in)
      begin
         lane_mask = ~lane_n;
      end
      else
      begin
         lane_mask = LANES_NONE;
      end
   end

   // Next state of the port for this edge
   always_comb
   begin
      st_d = st_q;
      // Pipeline stage: data of the cycle registered last edge
      st_d.rd_vld = (st_q.kind == SBS_READ);
      if (st_q.kind == SBS_READ)
      begin
         st_d.rd_data = mem_word;
      end
      if (sleep_request_in)
      begin
         // Standby: no cycles, burst dropped
         st_d.kind = SBS_SLEEP;
      end
      else if (proc_load)
      begin
         // New address, a read when selected, never a write
         st_d.addr_hi = addr_hi_in;
         st_d.start_lo = {burst_addr_bit_one_in, burst_addr_bit_zero_in};
         st_d.step = CNT_RST;
         st_d.kind = sel_now ? SBS_READ : SBS_DESEL;
      end
      else if (ctrl_load)
      begin
         // New address, read or write from write controls
         st_d.addr_hi = addr_hi_in;
         st_d.start_lo = {burst_addr_bit_one_in, burst_addr_bit_zero_in};
         st_d.step = CNT_RST;
         if (!sel_now)
         begin
            st_d.kind = SBS_DESEL;
         end
         else if (|lane_mask)
         begin
            st_d.kind = SBS_WRITE;
         end
         else
         begin
            st_d.kind = SBS_READ;
         end
      end
      else if (active)
      begin
         // Burst continues; step or wait
         if (!burst_step_n_in)
         begin
            st_d.step = CNT_W'(st_q.step + CNT_ONE);
         end
         st_d.kind = (|lane_mask) ? SBS_WRITE : SBS_READ;
      end
      else
      begin
         // Leaving standby or staying deselected
         st_d.kind = SBS_DESEL;
      end
   end

   // Address of the cycle taken this edge, low bits from counter
   assign wr_addr = {st_d.addr_hi,
                     burst_lo(st_d.start_lo, st_d.step,
                              burst_order_in)};
   // Address of the cycle registered last edge
   assign rd_addr = {st_q.addr_hi,
                     burst_lo(st_q.start_lo, st_q.step,
                              burst_order_in)};

   // Lanes actually stored this edge
   assign wr_lane = (st_d.kind == SBS_WRITE) ? lane_mask : LANES_NONE;

   // State register, frozen while clock enable is low
   always_ff @(posedge clk_sys_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= STATE_RST;
      end
      else if (clk_en_in)
      begin
         st_q <= st_d;
      end
   end

   // One storage array per lane
   generate
      for (genvar g = 0; g < LANES; g++)
      begin : g_lane
         // Lane storage
         logic [LANE_W-1:0] mem [0:MEM_DEPTH-1];

         // Lane write, data taken on the control edge
         always_ff @(posedge clk_sys_in)
         begin
            if (clk_en_in && rst_n && wr_lane[g])
            begin
               mem[wr_addr] <= din_word[g*LANE_W +: LANE_W];
            end
         end

         // Lane read for the pipeline stage
         assign mem_word[g*LANE_W +: LANE_W] = mem[rd_addr];
      end
   endgenerate

   // Drivers: output enable, valid read, no sleep, no gated write
   assign drive = !output_enable_n_in && st_q.rd_vld &&
                  !sleep_request_in &&
                  !(!byte_write_gate_n_in && !(&lane_n));

   // Lane output data from the pipeline register
   assign {data_lane3_out, data_lane2_out,
           data_lane1_out, data_lane0_out} = st_q.rd_data;

   // Same enable on every lane
   assign data_lane0_oe_out = drive;
   assign data_lane1_oe_out = drive;
   assign data_lane2_oe_out = drive;
   assign data_lane3_oe_out = drive;

   // Standby shown from the registered cycle kind
   assign standby_out = (st_q.kind == SBS_SLEEP);

endmodule : sbs_sram_port
